// ==== src/ead_decoder.sv ====
// effective-address decoder: classes the 5-bit code, forms the address,
// reports extension bytes and pointer post-increment
// assumes the fetch queue presents code, operand size and extension bytes together
// with eaValid, and the register file presents all eight word registers
//
// Contract
// - byte uses accumulator bits 7:0, word the lower half, long the lower plus upper half.
// - the active stack pointer and stack bank are the system or the user ones.
// - bank group one offers seven bank registers, group two the same minus program bank.
// - a 24-bit physical address splits into bits 15:0 low and 23:16 bank.
// - I/O operands address only the page from 000000 to 0000FF.
// - the extended immediate is an 8-bit value sign-extended to 16 bits.
// - short vectors are 0 to 15 in 4 bits, long vectors 0 to 255 in 8 bits.
// - codes 00-07 are register direct, 08-1F memory operands.
// - codes 00-07 pick byte or word register by code, long register by code over two.
// - codes 0C-0F address via word register 0-3 then add the operand size, no extension.
// - codes 10-17 add a signed one-byte displacement to word register 0-7.
// - codes 18-1B add a two-byte displacement to word register 0-3.
// - codes 1C and 1D add word register 7 to register 0 or 1, no extension.
// - code 1E adds a two-byte displacement to the program counter.
// - code 1F takes a two-byte direct address with the data bank.
// - the instruction length grows by the extension bytes of the code.
`timescale 1ns/1ps
`include "ead_defines.svh"
module ead_decoder (
	input wire logic clk_sys, // core clock, 50 MHz
	input wire logic resetn, // async reset, active low
	input wire logic eaValid, // code and extension bytes present this cycle
	input wire logic [4:0] eaCode, // effective-address field
	input wire ead_pkg::ead_size_type opSize, // operand size
	input wire logic [2:0] baseLength, // opcode bytes before extension
	input wire logic [15:0] extBytes, // extension, first byte in 7:0
	input wire logic [127:0] wordRegisters, // word register i in bits 16i+15:16i
	input wire logic [15:0] progCounter, // program counter after extension
	input wire logic [7:0] dataBankReg, // data bank
	input wire logic [7:0] additionalDataBankReg, // additional data bank
	input wire logic [7:0] systemStackBankReg, // system stack bank
	input wire logic [7:0] userStackBankReg, // user stack bank
	input wire logic [7:0] directPageReg, // direct page
	input wire logic [7:0] programBankReg, // program bank
	input wire logic systemStackSel, // 1 selects system stack
	input wire logic [15:0] userStackPointer, // user stack pointer
	input wire logic [15:0] systemStackPointer, // system stack pointer
	input wire logic [31:0] accValue, // accumulator
	input wire logic [7:0] immByte, // raw byte immediate / vector field
	input wire ead_pkg::ead_bank_type bankSel, // bank operand selector
	input wire logic bankGroupTwo, // 1 when the operand is of group two
	input wire logic [23:0] physicalDirectAddress, // 24-bit direct address
	input wire logic [7:0] ioOffset, // I/O operand offset
	output logic decodeValid, // results below valid, high one cycle per request
	output logic isRegDirect, // code 00..07
	output logic isMemory, // code 08..1F
	output logic [2:0] regIndex, // selected register number
	output logic [1:0] extCount, // extension bytes consumed
	output logic [3:0] instrLength, // total instruction bytes
	output logic [23:0] operandAddress, // bank:offset of operand
	output logic ptrWriteEn, // post-increment write-back strobe
	output logic [2:0] ptrWriteIndex, // register to write back
	output logic [15:0] ptrWriteValue, // incremented pointer
	output logic [7:0] bankOperand, // selected bank register
	output logic bankIllegal, // program bank asked in group two
	output logic [15:0] physAddrLow, // bits 15:0 of direct address
	output logic [7:0] physAddrBank, // bits 23:16 of direct address
	output logic [23:0] ioAddress, // I/O page address
	output logic [31:0] accOperand, // sized accumulator
	output logic [15:0] stackPointer, // active stack pointer
	output logic [7:0] currentStackBankReg, // active stack bank
	output logic [15:0] signExtendedByteImm, // sign-extended immediate
	output logic [3:0] shortVectorNumber, // short vector
	output logic [7:0] longVectorNumber // long vector
);
	typedef struct packed {
		logic valid;
		logic regDirect;
		logic memory;
		logic [2:0] idx;
		logic [1:0] ext;
		logic [3:0] len;
		logic [23:0] addr;
		logic wen;
		logic [2:0] widx;
		logic [15:0] wval;
		logic [7:0] bank;
		logic bankBad;
		logic [15:0] physLow;
		logic [7:0] physBank;
		logic [23:0] io;
	} ead_dec_state_type;
	ead_dec_state_type state_reg, state_next;
	logic [15:0] wreg [8];
	logic [15:0] sizeStep;
	logic [7:0] curStackBank;

	// unpack the flat register-file bus
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_wreg
			assign wreg[gi] = wordRegisters[16*gi +: 16];
		end
	endgenerate

	// size in bytes for post-increment
	always_comb begin
		unique case (opSize)
			ead_pkg::EAD_SIZE_BYTE: sizeStep = 16'h0001;
			ead_pkg::EAD_SIZE_WORD: sizeStep = 16'h0002;
			default: sizeStep = 16'h0004;
		endcase
	end

	assign curStackBank = systemStackSel ? systemStackBankReg : userStackBankReg;

	// decode; every result registered so outputs come straight from flops
	always_comb begin
		state_next = state_reg;
		state_next.valid = eaValid;
		state_next.wen = 1'b0;
		if (eaValid) begin
			state_next.regDirect = (eaCode < `EAD_CODE_MEM_BASE);
			state_next.memory = (eaCode >= `EAD_CODE_MEM_BASE);
			state_next.ext = `EAD_EXT_NONE;
			state_next.addr = 24'h000000;
			state_next.widx = eaCode[1:0] == 2'h0 ? 3'h0 : {1'b0, eaCode[1:0]};
			state_next.wval = 16'h0000;
			if (eaCode < `EAD_CODE_MEM_BASE) begin
				// long registers pair up, so code over two picks one
				state_next.idx = (opSize == ead_pkg::EAD_SIZE_LONG) ?
					{1'b0, eaCode[2:1]} : eaCode[2:0];
			end else if (eaCode < `EAD_CODE_INC_BASE) begin
				state_next.idx = {1'b0, eaCode[1:0]};
				state_next.addr = {dataBankReg, wreg[eaCode[1:0]]};
			end else if (eaCode < `EAD_CODE_D8_BASE) begin
				state_next.idx = {1'b0, eaCode[1:0]};
				state_next.addr = {dataBankReg, wreg[eaCode[1:0]]};
				state_next.wen = 1'b1;
				state_next.wval = wreg[eaCode[1:0]] + sizeStep;
			end else if (eaCode < `EAD_CODE_D16_BASE) begin
				state_next.idx = eaCode[2:0];
				state_next.ext = `EAD_EXT_ONE;
				state_next.addr = {dataBankReg,
					wreg[eaCode[2:0]] + {{8{extBytes[7]}}, extBytes[7:0]}};
			end else if (eaCode < `EAD_CODE_IDX0) begin
				state_next.idx = {1'b0, eaCode[1:0]};
				state_next.ext = `EAD_EXT_TWO;
				state_next.addr = {dataBankReg, wreg[eaCode[1:0]] + extBytes};
			end else if (eaCode == `EAD_CODE_IDX0 || eaCode == `EAD_CODE_IDX1) begin
				state_next.idx = {2'h0, eaCode[0]};
				state_next.addr = {dataBankReg,
					wreg[{2'h0, eaCode[0]}] + wreg[`EAD_INDEX_REG]};
			end else if (eaCode == `EAD_CODE_PCREL) begin
				state_next.idx = 3'h0;
				state_next.ext = `EAD_EXT_TWO;
				state_next.addr = {programBankReg, progCounter + extBytes};
			end else begin
				state_next.idx = 3'h0;
				state_next.ext = `EAD_EXT_TWO;
				state_next.addr = {dataBankReg, extBytes};
			end
			state_next.widx = {1'b0, eaCode[1:0]};
			// fetch skips the extension before the next opcode
			state_next.len = {1'b0, baseLength} + {2'h0, state_next.ext};
		end
		// bank operand groups; program bank absent from group two
		unique case (bankSel)
			ead_pkg::EAD_BANK_DATA: state_next.bank = dataBankReg;
			ead_pkg::EAD_BANK_ADD: state_next.bank = additionalDataBankReg;
			ead_pkg::EAD_BANK_SSTK: state_next.bank = systemStackBankReg;
			ead_pkg::EAD_BANK_USTK: state_next.bank = userStackBankReg;
			ead_pkg::EAD_BANK_DPAGE: state_next.bank = directPageReg;
			ead_pkg::EAD_BANK_PROG: state_next.bank = programBankReg;
			ead_pkg::EAD_BANK_CSTK: state_next.bank = curStackBank;
			default: state_next.bank = 8'h00;
		endcase
		state_next.bankBad = bankGroupTwo && (bankSel == ead_pkg::EAD_BANK_PROG);
		state_next.physLow = physicalDirectAddress[15:0];
		state_next.physBank = physicalDirectAddress[23:16];
		// upper bits forced low so only the first page can be reached
		state_next.io = {16'h0000, ioOffset} & `EAD_IO_PAGE_TOP;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// sized operands, stack, immediate and vectors
	ead_operand_slice u_slice (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.accValue(accValue),
		.opSize(opSize),
		.systemStackSel(systemStackSel),
		.userStackPointer(userStackPointer),
		.systemStackPointer(systemStackPointer),
		.userStackBankReg(userStackBankReg),
		.systemStackBankReg(systemStackBankReg),
		.immByte(immByte),
		.accOperand(accOperand),
		.stackPointer(stackPointer),
		.currentStackBankReg(currentStackBankReg),
		.signExtendedByteImm(signExtendedByteImm),
		.shortVectorNumber(shortVectorNumber),
		.longVectorNumber(longVectorNumber)
	);

	assign decodeValid = state_reg.valid;
	assign isRegDirect = state_reg.regDirect;
	assign isMemory = state_reg.memory;
	assign regIndex = state_reg.idx;
	assign extCount = state_reg.ext;
	assign instrLength = state_reg.len;
	assign operandAddress = state_reg.addr;
	assign ptrWriteEn = state_reg.wen;
	assign ptrWriteIndex = state_reg.widx;
	assign ptrWriteValue = state_reg.wval;
	assign bankOperand = state_reg.bank;
	assign bankIllegal = state_reg.bankBad;
	assign physAddrLow = state_reg.physLow;
	assign physAddrBank = state_reg.physBank;
	assign ioAddress = state_reg.io;
endmodule

// ==== src/ead_defines.svh ====
// constants for the effective-address decoder: code ranges, extension counts, I/O page top, index register
// assumes inclusion by bare name from the decoder files
`ifndef EAD_DEFINES_SVH
`define EAD_DEFINES_SVH
`define EAD_CODE_MEM_BASE 5'h08
`define EAD_CODE_INC_BASE 5'h0C
`define EAD_CODE_D8_BASE 5'h10
`define EAD_CODE_D16_BASE 5'h18
`define EAD_CODE_IDX0 5'h1C
`define EAD_CODE_IDX1 5'h1D
`define EAD_CODE_PCREL 5'h1E
`define EAD_CODE_DIRECT 5'h1F
`define EAD_EXT_NONE 2'h0
`define EAD_EXT_ONE 2'h1
`define EAD_EXT_TWO 2'h2
`define EAD_IO_PAGE_TOP 24'h0000FF
`define EAD_INDEX_REG 3'h7
`endif

// ==== src/ead_pkg.sv ====
// types shared by the effective-address decoder
// assumes nothing beyond a SystemVerilog compiler
package ead_pkg;
	typedef enum logic [1:0] {
		EAD_SIZE_BYTE = 2'h0,
		EAD_SIZE_WORD = 2'h1,
		EAD_SIZE_LONG = 2'h2
	} ead_size_type;
	typedef enum logic [2:0] {
		EAD_BANK_DATA = 3'h0,
		EAD_BANK_ADD = 3'h1,
		EAD_BANK_SSTK = 3'h2,
		EAD_BANK_USTK = 3'h3,
		EAD_BANK_DPAGE = 3'h4,
		EAD_BANK_PROG = 3'h5,
		EAD_BANK_CSTK = 3'h6
	} ead_bank_type;
	typedef enum logic [6:0] {
		EAD_MODE_REG = 7'h01,
		EAD_MODE_IND = 7'h02,
		EAD_MODE_INC = 7'h04,
		EAD_MODE_D8 = 7'h08,
		EAD_MODE_D16 = 7'h10,
		EAD_MODE_IDX = 7'h20,
		EAD_MODE_ABS = 7'h40
	} ead_mode_type;
endpackage

// ==== src/ead_operand_slice.sv ====
// operand helpers: accumulator slicing, stack/bank selection, immediates, vectors
// assumes one clock domain with the decoder; outputs registered
`timescale 1ns/1ps
`include "ead_defines.svh"
module ead_operand_slice (
	input wire logic clk_sys, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic [31:0] accValue, // full accumulator
	input wire ead_pkg::ead_size_type opSize, // operand size
	input wire logic systemStackSel, // 1 selects system stack
	input wire logic [15:0] userStackPointer, // user stack pointer
	input wire logic [15:0] systemStackPointer, // system stack pointer
	input wire logic [7:0] userStackBankReg, // user stack bank
	input wire logic [7:0] systemStackBankReg, // system stack bank
	input wire logic [7:0] immByte, // raw 8-bit immediate
	output logic [31:0] accOperand, // sized accumulator operand
	output logic [15:0] stackPointer, // active stack pointer
	output logic [7:0] currentStackBankReg, // active stack bank
	output logic [15:0] signExtendedByteImm, // sign-extended immediate
	output logic [3:0] shortVectorNumber, // vector 0..15
	output logic [7:0] longVectorNumber // vector 0..255
);
	typedef struct packed {
		logic [31:0] acc;
		logic [15:0] sp;
		logic [7:0] current_stack_bank_reg;
		logic [15:0] imm;
		logic [3:0] vs;
		logic [7:0] vl;
	} ead_slice_state_type;
	ead_slice_state_type state_reg, state_next;
	// next-state: all helpers combinational then registered
	always_comb begin
		state_next = state_reg;
		unique case (opSize)
			ead_pkg::EAD_SIZE_BYTE: state_next.acc = {24'h000000, accValue[7:0]};
			ead_pkg::EAD_SIZE_WORD: state_next.acc = {16'h0000, accValue[15:0]};
			default: state_next.acc = accValue;
		endcase
		state_next.sp = systemStackSel ? systemStackPointer : userStackPointer;
		state_next.current_stack_bank_reg = systemStackSel ? systemStackBankReg : userStackBankReg;
		state_next.imm = {{8{immByte[7]}}, immByte};
		state_next.vs = immByte[3:0];
		state_next.vl = immByte;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign accOperand = state_reg.acc;
	assign stackPointer = state_reg.sp;
	assign currentStackBankReg = state_reg.current_stack_bank_reg;
	assign signExtendedByteImm = state_reg.imm;
	assign shortVectorNumber = state_reg.vs;
	assign longVectorNumber = state_reg.vl;
endmodule

// ==== testbench/ead_decoder_monitor.sv ====
// concurrent checks on the effective-address decoder ports
// assumes a single clock domain; bound to every decoder instance below
`timescale 1ns/1ps
module ead_decoder_monitor (
	input wire logic clk_sys, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic eaValid, // request
	input wire logic [4:0] eaCode, // code
	input wire logic [2:0] baseLength, // opcode bytes
	input wire logic [7:0] immByte, // immediate
	input wire logic [23:0] physicalDirectAddress, // direct address
	input wire logic [7:0] ioOffset, // I/O offset
	input wire logic decodeValid, // answer strobe
	input wire logic isRegDirect, // register class
	input wire logic isMemory, // memory class
	input wire logic [1:0] extCount, // extension bytes
	input wire logic [3:0] instrLength, // instruction bytes
	input wire logic ptrWriteEn, // post-increment strobe
	input wire logic [2:0] ptrWriteIndex, // post-increment register
	input wire logic [15:0] physAddrLow, // low part
	input wire logic [7:0] physAddrBank, // bank part
	input wire logic [23:0] ioAddress, // I/O page address
	input wire logic [15:0] signExtendedByteImm // extended immediate
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// helpers lag one edge, so they are only judged once an edge out of reset has passed
	class_split_a: assert property (eaValid |=> decodeValid && isMemory != isRegDirect
		&& isRegDirect == ($past(eaCode) < 5'h08)) else $error("class wrong");
	ext_none_a: assert property (eaValid
		&& (eaCode[4:3] == 2'h1 || eaCode[4:1] == 4'hE)
		|=> extCount == 2'h0) else $error("extension not zero");
	ext_one_a: assert property (eaValid && eaCode[4:3] == 2'h2 |=> extCount == 2'h1)
		else $error("extension not one");
	ext_two_a: assert property (eaValid
		&& (eaCode[4:2] == 3'h6 || eaCode[4:1] == 4'hF)
		|=> extCount == 2'h2) else $error("extension not two");
	length_sum_a: assert property (decodeValid |->
		instrLength == {1'b0, $past(baseLength)} + {2'b0, extCount}) else $error("length wrong");
	post_inc_a: assert property (eaValid && eaCode[4:2] == 3'h3 |=> ptrWriteEn
		&& ptrWriteIndex == {1'b0, $past(eaCode[1:0])}) else $error("no write-back");
	no_inc_a: assert property (!eaValid || eaCode[4:2] != 3'h3 |=> !ptrWriteEn)
		else $error("stray write-back");
	phys_split_a: assert property ($past(resetn) |->
		{physAddrBank, physAddrLow} == $past(physicalDirectAddress)) else $error("split wrong");
	io_page_a: assert property ($past(resetn) |-> ioAddress == {16'h0000, $past(ioOffset)})
		else $error("outside I/O page");
	sign_ext_a: assert property ($past(resetn) |-> signExtendedByteImm
		== {{8{$past(immByte[7])}}, $past(immByte)}) else $error("sign extension wrong");
endmodule
bind ead_decoder ead_decoder_monitor i_ead_decoder_monitor (.*);

// ==== testbench/ead_fetch_queue_model.sv ====
// stand-in for the fetch queue: presents queued codes with their extension bytes
// assumes the bench pushes entries; slowMode leaves idle cycles between them
`timescale 1ns/1ps
module ead_fetch_queue_model (
	input wire logic clk_sys, // core clock
	input wire logic slowMode, // 1 stalls two cycles per entry
	output logic eaValid, // request
	output logic [4:0] eaCode, // code
	output ead_pkg::ead_size_type opSize, // size
	output logic [2:0] baseLength, // opcode bytes
	output logic [15:0] extBytes // extension, disp16 as one word
);
	logic [25:0] fifo[$];
	logic [25:0] e;
	logic [1:0] sz = 2'h0;
	int gap = 0;
	assign opSize = ead_pkg::ead_size_type'(sz);
	initial begin
		{eaValid, eaCode, baseLength, extBytes} = 25'h0;
	end
	task automatic push(input logic [25:0] v);
		fifo.push_back(v);
	endtask
	// idle cycles scramble code and extension so nothing stale passes for a request
	always @(negedge clk_sys) begin
		if (gap == 0 && fifo.size() != 0) begin
			e = fifo.pop_front();
			eaValid <= 1'b1;
			{eaCode, sz, baseLength, extBytes} <= e;
			gap = slowMode ? 2 : 0;
		end else begin
			eaValid <= 1'b0;
			eaCode <= ~eaCode;
			extBytes <= ~extBytes;
			if (gap != 0) gap = gap - 1;
		end
	end
endmodule

// ==== testbench/test_effective_address_decoder.sv ====
// self-checking bench: integer model of the decoder compared at every result
// assumes the fetch-queue model drives the request side and the bench the rest
`timescale 1ns/1ps
module test_effective_address_decoder;
	logic clk_sys = 0, resetn = 0, slowMode = 0, eaValid, systemStackSel, bankGroupTwo, hIll;
	logic decodeValid, isRegDirect, isMemory, ptrWriteEn, bankIllegal, live = 0;
	logic [4:0] eaCode;
	logic [2:0] baseLength, regIndex, ptrWriteIndex;
	logic [1:0] extCount;
	logic [3:0] instrLength, shortVectorNumber;
	logic [7:0] dataBankReg, additionalDataBankReg, systemStackBankReg, userStackBankReg;
	logic [7:0] directPageReg, programBankReg, immByte, ioOffset, bankOperand, physAddrBank;
	logic [7:0] currentStackBankReg, longVectorNumber, hBank, hIo, hImm;
	logic [15:0] extBytes, progCounter, userStackPointer, systemStackPointer, ptrWriteValue;
	logic [15:0] physAddrLow, stackPointer, signExtendedByteImm;
	logic [23:0] physicalDirectAddress, operandAddress, ioAddress, hStk, hPhys;
	logic [31:0] accValue, accOperand, r, hAcc;
	logic [127:0] wordRegisters;
	logic [63:0] bv;
	logic [53:0] e;
	logic [53:0] expq[$];
	ead_pkg::ead_size_type opSize;
	ead_pkg::ead_bank_type bankSel;
	int n_fail = 0, n_tests = 0;
	integer seed = 32'h46996a93;
	ead_decoder i_ead_decoder (.*);
	ead_fetch_queue_model i_ead_fetch_queue_model (.*);
	initial forever #10 clk_sys = ~clk_sys;
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	function automatic logic [15:0] rw(input int i);
		return wordRegisters[16*i +: 16];
	endfunction
	// expected {class, index, ext, length, address, write-back} of one request
	function automatic logic [53:0] dec(input logic [4:0] c, input int sz, input logic [2:0] bl,
		input logic [15:0] x);
		int j, o, ex, pv;
		logic [7:0] bk;
		j = c[1:0];
		ex = 0;
		o = 0;
		bk = dataBankReg;
		pv = rw(j) + (1 << sz);
		if (c < 8) j = (sz == 2) ? c >> 1 : c;
		else if (c < 16) o = rw(j);
		else if (c < 24) begin
			j = c[2:0];
			o = rw(j) + int'($signed(x[7:0]));
			ex = 1;
		end else if (c < 28) begin
			o = rw(j) + x;
			ex = 2;
		end else if (c < 30) begin
			j = c[0];
			o = rw(j) + rw(7);
		end else begin
			j = 0;
			ex = 2;
			o = (c == 30) ? progCounter + x : x;
			if (c == 30) bk = programBankReg;
		end
		return {c < 8, 3'(j), 2'(ex), 4'(bl + ex), bk, 16'(o), c[4:2] == 3'h3, 3'(j), 16'(pv)};
	endfunction
	// the rest of the inputs take fresh random values each cycle
	task automatic drive();
		wordRegisters = {$random(seed), $random(seed), $random(seed), $random(seed)};
		{progCounter, dataBankReg, additionalDataBankReg} = $random(seed);
		{systemStackBankReg, userStackBankReg, directPageReg, programBankReg} = $random(seed);
		{userStackPointer, systemStackPointer} = $random(seed);
		accValue = $random(seed);
		{physicalDirectAddress, ioOffset} = $random(seed);
		r = $random(seed);
		{immByte, systemStackSel, bankGroupTwo} = r[9:0];
		bankSel = ead_pkg::ead_bank_type'(r[12:10]);
	endtask
	initial begin
		drive();
		forever @(negedge clk_sys) drive();
	end
	// model samples what the design samples at the same edge
	always @(posedge clk_sys) begin
		live <= resetn;
		if (eaValid && resetn) expq.push_back(dec(eaCode, opSize, baseLength, extBytes));
		if (opSize == ead_pkg::EAD_SIZE_BYTE) hAcc = {24'h0, accValue[7:0]};
		else if (opSize == ead_pkg::EAD_SIZE_WORD) hAcc = {16'h0, accValue[15:0]};
		else hAcc = accValue;
		hStk = systemStackSel ? {systemStackPointer, systemStackBankReg}
			: {userStackPointer, userStackBankReg};
		bv = {8'h00, hStk[7:0], programBankReg, directPageReg, userStackBankReg,
			systemStackBankReg, additionalDataBankReg, dataBankReg};
		hBank = bv[8*bankSel +: 8];
		hIll = bankSel == ead_pkg::EAD_BANK_PROG && bankGroupTwo;
		{hPhys, hIo, hImm} = {physicalDirectAddress, ioOffset, immByte};
	end
	// outputs are judged half a cycle after the edge that produced them
	always @(negedge clk_sys) begin
		if (live && resetn) begin
			cmp(decodeValid, expq.size() != 0);
			if (decodeValid === 1'b1 && expq.size() != 0) begin
				e = expq.pop_front();
				cmp({isRegDirect, isMemory}, {e[53], !e[53]});
				cmp(regIndex, e[52:50]);
				cmp({extCount, instrLength}, e[49:44]);
				if (!e[53]) cmp(operandAddress, e[43:20]);
				cmp(ptrWriteEn, e[19]);
				if (e[19]) cmp({ptrWriteIndex, ptrWriteValue}, e[18:0]);
			end
			cmp(accOperand, hAcc);
			cmp({stackPointer, currentStackBankReg}, hStk);
			cmp(bankIllegal, hIll);
			if (!hIll) cmp(bankOperand, hBank);
			cmp({physAddrBank, physAddrLow}, hPhys);
			cmp(ioAddress, {16'h0000, hIo});
			cmp(signExtendedByteImm, {{8{hImm[7]}}, hImm});
			cmp({shortVectorNumber, longVectorNumber}, {hImm[3:0], hImm});
		end
		if (!resetn) expq.delete();
	end
	task automatic drain();
		while (i_ead_fetch_queue_model.fifo.size() != 0) @(negedge clk_sys);
		repeat (4) @(negedge clk_sys);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys) resetn <= 1'b1;
		// every code at every size, back to back
		for (int c = 0; c < 32; c++)
			for (int s = 0; s < 3; s++)
				i_ead_fetch_queue_model.push({5'(c), 2'(s), 3'($random(seed)), 16'($random(seed))});
		drain();
		$display("test sweep done");
		// reset in mid-run, then random codes with the queue stalling
		@(negedge clk_sys) resetn <= 1'b0;
		@(negedge clk_sys) resetn <= 1'b1;
		slowMode = 1'b1;
		repeat (200)
			i_ead_fetch_queue_model.push({5'($random(seed)), 2'($unsigned($random(seed)) % 3),
				3'($random(seed)), 16'($random(seed))});
		drain();
		$display("test random done");
		results();
	end
	// cut a hang short well past the expected run of under a thousand cycles
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule
